// *** hdl/mrc_mode_reg_one.sv ***
/*
  Mode register one: driver impedance, termination, clock-loop reset,
  calibration control, refresh protocol and burst length.
  Assumes command pins are already sampled on the device clock mclk_in and
  that the read datapath flags its first and last driven beats.
*/
`timescale 1ns/100ps
module mrc_mode_reg_one #(
  parameter logic [15:0] CAL_INIT_CYC = 16'(mrc_pkg::CAL_INIT_CYC),
  parameter logic [15:0] CAL_OPER_CYC = 16'(mrc_pkg::CAL_OPER_CYC)
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Command pins
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        ref_n_in,
  input  wire logic [20:0] addr_in,
  input  wire logic [3:0]  bank_in,
  // Configuration strap and read datapath
  input  wire logic        wide_config_in,
  input  wire logic        read_drive_start_in,
  input  wire logic        read_last_beat_in,
  // Register view
  output logic [10:0]      cfg_out,
  // Driver and termination
  output logic [1:0]       drive_sel_out,
  output logic [2:0]       rtt_sel_out,
  output logic             dq_term_on_out,
  output logic             mask_clk_term_on_out,
  // Clock loop
  output logic             dll_reset_out,
  output logic             dll_locked_out,
  // Calibration
  output logic             cal_busy_out,
  output logic             cal_long_out,
  output logic             cal_update_out,
  output logic             rzq_current_on_out,
  output logic             read_clk_valid_out,
  // Refresh
  output logic             refresh_out,
  output logic [15:0]      refresh_banks_out,
  // Burst length
  output logic [1:0]       burst_len_out,
  output logic [4:0]       addr_width_out,
  output logic             burst_illegal_out
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Bank number to one-hot refresh mask.
  function automatic logic [15:0] bank_mask(input logic [3:0] b);
    bank_mask = 16'h0001 << b;
  endfunction : bank_mask

  function automatic logic [4:0] addr_bits(input logic [1:0] bl, input logic wide);
    logic [4:0] w;
    w = mrc_pkg::AW_19;
    if (bl == mrc_pkg::BL_2) begin
      w = wide ? mrc_pkg::AW_20 : mrc_pkg::AW_21;
    end else if (bl == mrc_pkg::BL_4) begin
      w = wide ? mrc_pkg::AW_19 : mrc_pkg::AW_20;
    end
    addr_bits = w;
  endfunction : addr_bits

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [10:0] cfg_r;
  logic [10:0] cfg_nxt;
  logic        wide_r;
  logic        strap_done_r;
  logic        reading_r;
  logic        reading_nxt;
  logic [9:0]  lock_cnt_r;
  logic [9:0]  lock_cnt_nxt;
  logic        cal_busy;
  logic        cal_done;
  logic        is_cmd;
  logic        mrs_cmd;
  logic        mr1_wr;
  logic        auto_refresh_command_cmd;
  logic        cal_start;
  logic [2:0]  odt_code;
  logic        odt_en;
  logic [2:0]  rtt_dec;
  logic [1:0]  bl_code;
  logic [15:0] ref_mask;

  // ==========================================================================
  // Command decode
  // ==========================================================================
  // Decodes mode register and refresh commands from the pins.
  assign is_cmd   = !cs_n_in;
  assign mrs_cmd  = is_cmd && !we_n_in && !ref_n_in;
  assign auto_refresh_command_cmd = is_cmd && we_n_in && !ref_n_in;
  assign mr1_wr    = mrs_cmd && (bank_in[1:0] == mrc_pkg::MR1_SEL);
  assign cal_start = mr1_wr && addr_in[mrc_pkg::CAL_GO_BIT];

  // ==========================================================================
  // Register next value
  // ==========================================================================
  // Self-clearing bits drop after use; a new write wins over a clear.
  always_comb begin
    cfg_nxt = cfg_r;
    if (mr1_wr) begin
      cfg_nxt = addr_in[mrc_pkg::CFG_W-1:0];
    end else begin
      cfg_nxt[mrc_pkg::DLL_BIT] = 1'b0;
      if (cal_done) begin
        cfg_nxt[mrc_pkg::CAL_GO_BIT] = 1'b0;
      end
    end
  end

  // contents other than DLL_BIT and CAL_GO_BIT held until rewritten or reset
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r <= mrc_pkg::CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Captures the data width strap once after reset release.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wide_r       <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      wide_r       <= wide_config_in;
      strap_done_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Termination
  // ==========================================================================
  // code-to-setting mapping as constants
  assign odt_code = cfg_r[mrc_pkg::ODT_LSB +: 3];
  assign rtt_dec  = {odt_code == mrc_pkg::ODT_120,
                     odt_code == mrc_pkg::ODT_60,
                     odt_code == mrc_pkg::ODT_40};
  assign odt_en   = (rtt_dec != 3'h0);

  always_comb begin
    reading_nxt = reading_r;
    if (read_drive_start_in) begin
      reading_nxt = 1'b1;
    end else if (read_last_beat_in) begin
      reading_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // Clock-loop lock timer
  // ==========================================================================
  // Counts the settle period after each clock-loop reset pulse.
  always_comb begin
    lock_cnt_nxt = lock_cnt_r;
    if (dll_reset_out) begin
      lock_cnt_nxt = 10'(mrc_pkg::DLL_LOCK_CYC - 1);
    end else if (lock_cnt_r != 10'h000) begin
      lock_cnt_nxt = lock_cnt_r - 10'h001;
    end
  end

  // ==========================================================================
  // Refresh and burst decode
  // ==========================================================================
  // single or multibank select
  assign ref_mask = cfg_r[mrc_pkg::REF_BIT] ? addr_in[mrc_pkg::BANKS-1:0]
                                            : bank_mask(bank_in);
  assign bl_code  = cfg_r[mrc_pkg::BL_LSB +: 2];

  // ==========================================================================
  // Calibration engine
  // ==========================================================================
  // long or short selection
  mrc_cal_engine #(
    .INIT_CYC  (CAL_INIT_CYC),
    .OPER_CYC  (CAL_OPER_CYC),
    .SHORT_CYC (16'(mrc_pkg::CAL_SHORT_CYC))
  ) u_cal (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .start_in (cal_start),
    .long_in  (addr_in[mrc_pkg::CAL_LONG_BIT]),
    .busy_out (cal_busy),
    .done_out (cal_done)
  );

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Registers every output and the internal trackers.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reading_r          <= 1'b0;
      lock_cnt_r         <= 10'h000;
      cfg_out            <= mrc_pkg::CFG_RESET;
      drive_sel_out      <= mrc_pkg::DRV_LOW_OHM;
      rtt_sel_out        <= 3'h0;
      dq_term_on_out     <= 1'b0;
      mask_clk_term_on_out <= 1'b0;
      dll_reset_out      <= 1'b0;
      dll_locked_out     <= 1'b0;
      cal_busy_out       <= 1'b0;
      cal_long_out       <= 1'b0;
      cal_update_out     <= 1'b0;
      rzq_current_on_out <= 1'b0;
      read_clk_valid_out <= 1'b1;
      refresh_out        <= 1'b0;
      refresh_banks_out  <= 16'h0000;
      burst_len_out      <= mrc_pkg::BL_2;
      addr_width_out     <= mrc_pkg::AW_21;
      burst_illegal_out  <= 1'b0;
    end else begin
      reading_r          <= reading_nxt;
      lock_cnt_r         <= lock_cnt_nxt;
      cfg_out            <= cfg_r;
      drive_sel_out      <= cfg_r[mrc_pkg::DRV_LSB +: 2];
      rtt_sel_out        <= rtt_dec;
      dq_term_on_out     <= odt_en && !reading_nxt;
      mask_clk_term_on_out <= odt_en;
      dll_reset_out      <= cfg_r[mrc_pkg::DLL_BIT];
      dll_locked_out     <= (lock_cnt_nxt == 10'h000) && !dll_reset_out;
      cal_busy_out       <= cal_busy;
      if (cal_start) begin
        cal_long_out <= addr_in[mrc_pkg::CAL_LONG_BIT];
      end
      cal_update_out     <= cal_done;
      rzq_current_on_out <= cal_busy;
      read_clk_valid_out <= !cal_busy;
      refresh_out        <= auto_refresh_command_cmd;
      if (auto_refresh_command_cmd) begin
        refresh_banks_out <= ref_mask;
      end
      burst_len_out      <= bl_code;
      addr_width_out     <= addr_bits(bl_code, wide_r);
      burst_illegal_out  <= wide_r && (bl_code == mrc_pkg::BL_8);
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // write stores address
  a_mr1_write_store: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mr1_wr && !addr_in[mrc_pkg::DLL_BIT]) |=> (cfg_r == $past(addr_in[mrc_pkg::CFG_W-1:0])))
    else $error("Register write not stored.");

  a_dll_self_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (mr1_wr && addr_in[mrc_pkg::DLL_BIT]) ##1 !mr1_wr |=> !cfg_r[mrc_pkg::DLL_BIT] && dll_reset_out)
    else $error("Clock-loop reset bit did not self-clear.");

  a_cal_go_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cal_done && !mr1_wr) |=> !cfg_r[mrc_pkg::CAL_GO_BIT])
    else $error("Calibration start bit not cleared.");

  a_cal_launch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cal_start |=> cal_busy ##1 cal_busy_out)
    else $error("Calibration did not start.");

  // read drive turns off data termination
  a_dq_term_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    read_drive_start_in |=> !dq_term_on_out && (mask_clk_term_on_out == $past(odt_en)))
    else $error("Data termination on during read.");

  a_dm_term_on: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (odt_en && $stable(cfg_r)) |=> mask_clk_term_on_out)
    else $error("Mask termination dropped.");

  a_rzq_off_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (cal_done && !cal_start) |=> cal_update_out && !rzq_current_on_out)
    else $error("Calibration pin current still on.");

  a_multibank_mask: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (auto_refresh_command_cmd && cfg_r[mrc_pkg::REF_BIT]) |=> refresh_out &&
      (refresh_banks_out == $past(addr_in[mrc_pkg::BANKS-1:0])))
    else $error("Multibank refresh mask wrong.");

  a_single_bank_mask: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (auto_refresh_command_cmd && !cfg_r[mrc_pkg::REF_BIT]) |=> $onehot(refresh_banks_out))
    else $error("Single-bank refresh mask not one-hot.");

  // wide burst two gives twenty bits
  a_addr_width_wide: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (wide_r && bl_code == mrc_pkg::BL_2) |=> (addr_width_out == mrc_pkg::AW_20))
    else $error("Address width wrong for wide burst two.");

  a_drive_reset_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(strap_done_r) |-> (drive_sel_out == mrc_pkg::DRV_LOW_OHM))
    else $error("Driver not at low impedance after reset.");

endmodule : mrc_mode_reg_one

// *** hdl/mrc_pkg.sv ***
/*
  Constants, field layout and encodings for the mode register one block.
  Assumes a single device clock domain; all users write mrc_pkg::name.
*/
// Functional notes
// - Two low bits pick driver impedance; reset gives the lower impedance.
// - Three-bit field selects termination of data, write clock and mask.
// - Data termination off while driving read data, back on after last beat.
// - Mask and write clock inputs stay terminated whenever termination is enabled.
// - Writing one to the clock-loop reset bit starts a reset; bit self-clears.
// - One bit selects long or short calibration.
// - Start bit launches calibration and clears itself when calibration ends.
// - On completion, values move to the I/O and calibration pin current stops.
// - Calibration may overlap a clock-loop reset and its locking period.
// - Short calibration finishes its correction within 64 clock cycles.
// - Read output clock state is undefined while calibration runs.
// - Refresh-mode bit picks single-bank or multibank refresh.
// - In multibank refresh each of sixteen address bits marks one bank.
// - Two bits set burst length 2, 4 or 8; 8 not allowed wide.
// - Address width follows burst length and data width configuration.
// - Mode command stores address into register chosen by bank bits.
// - Register holds until rewritten, reset asserted, or power lost.
package mrc_pkg;

  // ==========================================================================
  // Register layout
  // ==========================================================================
  localparam int          CFG_W       = 11;
  localparam logic [1:0]  MR1_SEL     = 2'h1;
  localparam logic [10:0] CFG_RESET   = 11'h000;
  localparam int          DRV_LSB     = 0;
  localparam int          ODT_LSB     = 2;
  localparam int          DLL_BIT     = 5;
  localparam int          CAL_LONG_BIT = 6;
  localparam int          CAL_GO_BIT  = 7;
  localparam int          REF_BIT     = 8;
  localparam int          BL_LSB      = 9;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [1:0] DRV_LOW_OHM = 2'h0;
  localparam logic [2:0] ODT_OFF     = 3'h0;
  localparam logic [2:0] ODT_40      = 3'h1;
  localparam logic [2:0] ODT_60      = 3'h2;
  localparam logic [2:0] ODT_120     = 3'h3;
  localparam logic [1:0] BL_2        = 2'h0;
  localparam logic [1:0] BL_4        = 2'h1;
  localparam logic [1:0] BL_8        = 2'h2;

  // ==========================================================================
  // Address widths and timing
  // ==========================================================================
  localparam logic [4:0] AW_21 = 5'h15;
  localparam logic [4:0] AW_20 = 5'h14;
  localparam logic [4:0] AW_19 = 5'h13;
  localparam int         DLL_LOCK_CYC   = 512;
  localparam int         CAL_SHORT_CYC  = 64;
  localparam int         CAL_INIT_CYC   = 1024;
  localparam int         CAL_OPER_CYC   = 256;
  localparam int         CNT_W          = 16;
  localparam int         BANKS          = 16;

endpackage : mrc_pkg

// *** hdl/mrc_cal_engine.sv ***
/*
  Impedance calibration sequencer: runs a timed long or short window.
  Assumes a one-cycle start pulse from the register logic on the same clock.
*/
`timescale 1ns/100ps
module mrc_cal_engine #(
  parameter logic [15:0] INIT_CYC  = 16'(mrc_pkg::CAL_INIT_CYC),
  parameter logic [15:0] OPER_CYC  = 16'(mrc_pkg::CAL_OPER_CYC),
  parameter logic [15:0] SHORT_CYC = 16'(mrc_pkg::CAL_SHORT_CYC)
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic start_in,
  input  wire logic long_in,
  // Status
  output logic      busy_out,
  output logic      done_out
);

  logic [15:0] cnt_r;
  logic        init_done_r;
  logic [15:0] len;

  // ==========================================================================
  // Window length
  // ==========================================================================
  // short, init or operating window
  assign len = !long_in ? SHORT_CYC : (init_done_r ? OPER_CYC : INIT_CYC);

  // Counts the window down; a new start reloads it.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r       <= 16'h0000;
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      init_done_r <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_r    <= len - 16'h0001;
        busy_out <= 1'b1;
        if (long_in) begin
          init_done_r <= 1'b1;
        end
      end else if (busy_out) begin
        cnt_r <= cnt_r - 16'h0001;
        if (cnt_r == 16'h0000) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

  a_short_window_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (start_in && !long_in) |=> busy_out [*8] ##57 (done_out || start_in || $past(start_in)))
    else $error("Short calibration window length wrong.");

endmodule : mrc_cal_engine

// *** dv/mrc_ctrl_model.sv ***
/*
  Memory controller model that issues mode register and refresh commands.
  Assumes one device clock; callers use its tasks from the testbench.
*/
`timescale 1ns/100ps
module mrc_ctrl_model (
  // Clock
  input  wire logic        mclk_in,
  // Command pins toward the device
  output logic             cs_n_out,
  output logic             we_n_out,
  output logic             ref_n_out,
  output logic [20:0]      addr_out,
  output logic [3:0]       bank_out
);
  // Pins start deselected.
  initial begin
    cs_n_out  = 1'b1;
    we_n_out  = 1'b1;
    ref_n_out = 1'b1;
    addr_out  = 21'h000000;
    bank_out  = 4'h0;
  end

  // Deselect; address and bank show the inverse of their last value.
  task automatic idle();
    cs_n_out  <= 1'b1;
    we_n_out  <= 1'b1;
    ref_n_out <= 1'b1;
    addr_out  <= ~addr_out;
    bank_out  <= ~bank_out;
  endtask : idle

  // Upper bank and reserved bits low; no reads issued.
  task automatic mode_register_set_command(input logic [1:0] sel, input logic [10:0] v);
    @(posedge mclk_in);
    cs_n_out  <= 1'b0;
    we_n_out  <= 1'b0;
    ref_n_out <= 1'b0;
    bank_out  <= {2'h0, sel};
    addr_out  <= {10'h000, v};
    @(posedge mclk_in);
    idle();
  endtask : mode_register_set_command

  // Refresh command with a bank and a bank mask.
  task automatic auto_refresh_command(input logic [3:0] b, input logic [15:0] a);
    @(posedge mclk_in);
    cs_n_out  <= 1'b0;
    we_n_out  <= 1'b1;
    ref_n_out <= 1'b0;
    bank_out  <= b;
    addr_out  <= {5'h00, a};
    @(posedge mclk_in);
    idle();
  endtask : auto_refresh_command
endmodule : mrc_ctrl_model

// *** dv/tb.sv ***
/*
  Self-checking testbench for the mode register one block.
  Assumes the controller model in mrc_ctrl_model and a 25 MHz clock.
*/
`timescale 1ns/100ps
module tb;
  localparam int INIT_CYC = 8;
  localparam int OPER_CYC = 4;
  logic        mclk_in  = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wide     = 1'b0;
  logic        rd_start = 1'b0;
  logic        rd_last  = 1'b0;
  logic        cs_n, we_n, ref_n, dq_t, mck_t, dll_rst, dll_lk, busy, clong, upd, calibration_resistor_pin, rclk_ok, refr, bl_bad;
  logic [20:0] addr;
  logic [3:0]  bank;
  logic [10:0] cfg;
  logic [1:0]  drv, bl;
  logic [2:0]  termination_resistance;
  logic [4:0]  aw;
  logic [15:0] rbanks;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;

  mrc_ctrl_model u_ctrl (.mclk_in(mclk_in), .cs_n_out(cs_n), .we_n_out(we_n), .ref_n_out(ref_n),
    .addr_out(addr), .bank_out(bank));
  mrc_mode_reg_one #(.CAL_INIT_CYC(16'h0008), .CAL_OPER_CYC(16'h0004)) dut (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .cs_n_in(cs_n), .we_n_in(we_n), .ref_n_in(ref_n), .addr_in(addr), .bank_in(bank),
    .wide_config_in(wide), .read_drive_start_in(rd_start), .read_last_beat_in(rd_last), .cfg_out(cfg),
    .drive_sel_out(drv), .rtt_sel_out(termination_resistance), .dq_term_on_out(dq_t), .mask_clk_term_on_out(mck_t),
    .dll_reset_out(dll_rst), .dll_locked_out(dll_lk), .cal_busy_out(busy), .cal_long_out(clong),
    .cal_update_out(upd), .rzq_current_on_out(calibration_resistor_pin), .read_clk_valid_out(rclk_ok), .refresh_out(refr),
    .refresh_banks_out(rbanks), .burst_len_out(bl), .addr_width_out(aw), .burst_illegal_out(bl_bad));

  // Clock and hang guard.
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Holds reset for 16 edges, releases it on an edge and checks the reset state.
  task automatic t_reset(input logic w);
    rst_n_in <= 1'b0;
    wide     <= w;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk(cfg, mrc_pkg::CFG_RESET);
    chk(drv, mrc_pkg::DRV_LOW_OHM);
    chk({dll_lk, rclk_ok, aw}, {2'h3, mrc_pkg::AW_21});
    $display("test reset done");
  endtask : t_reset

  // Walks the field codes through the register, with a foreign register write after each.
  task automatic t_fields();
    logic [10:0] v;
    logic [2:0]  rtt_exp;
    for (int i = 0; i < 6; i++) begin
      v       = {i[1:0], 1'b0, 3'h0, i[2:0], 1'b0, i[0]};
      rtt_exp = (i >= 1 && i <= 3) ? 3'(3'h1 << (i - 1)) : 3'h0;
      u_ctrl.mode_register_set_command(2'h1, v);
      u_ctrl.mode_register_set_command(2'h0, 11'h7FF);
      #1;
      chk(cfg, v);
      chk(drv, {1'b0, i[0]});
      chk(termination_resistance, rtt_exp);
      chk({dq_t, mck_t}, {2{rtt_exp != 3'h0}});
      chk({bl_bad, bl}, {1'b0, i[1:0]});
      chk(aw, i[1:0] == 2'h0 ? mrc_pkg::AW_21 : i[1:0] == 2'h1 ? mrc_pkg::AW_20 : mrc_pkg::AW_19);
    end
    $display("test fields done");
  endtask : t_fields

  // Starts a clock-loop reset and counts the edges until lock returns.
  task automatic t_dll();
    u_ctrl.mode_register_set_command(2'h1, 11'h020);
    @(posedge mclk_in);
    #1;
    chk({dll_rst, cfg[mrc_pkg::DLL_BIT]}, 2'h3);
    @(posedge mclk_in);
    #1;
    chk({dll_rst, dll_lk, cfg[mrc_pkg::DLL_BIT]}, 3'h0);
    n = 1;
    while (dll_lk !== 1'b1 && n < 600) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    chk(n, mrc_pkg::DLL_LOCK_CYC);
    $display("test dll done");
  endtask : t_dll

  // Channel stays quiet until the window ends.
  task automatic run_cal(input logic [10:0] v, input int cyc);
    u_ctrl.mode_register_set_command(2'h1, v);
    @(posedge mclk_in);
    #1;
    chk({cfg[mrc_pkg::CAL_GO_BIT], busy, calibration_resistor_pin, rclk_ok}, 4'hE);
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    chk(n, cyc);
    chk({upd, calibration_resistor_pin, rclk_ok}, 3'h5);
    chk(clong, v[mrc_pkg::CAL_LONG_BIT]);
    @(posedge mclk_in);
    #1;
    chk({upd, cfg[mrc_pkg::CAL_GO_BIT]}, 2'h0);
  endtask : run_cal

  // Short, first long and later long windows; the last overlaps a clock-loop reset.
  task automatic t_cal();
    run_cal(11'h080, mrc_pkg::CAL_SHORT_CYC);
    run_cal(11'h0C0, INIT_CYC);
    run_cal(11'h0E0, OPER_CYC);
    chk({dll_lk, busy}, 2'h0);
    $display("test calibration done");
  endtask : t_cal

  // Single-bank then multibank refresh; the pulse stands for one cycle.
  task automatic t_refresh();
    u_ctrl.mode_register_set_command(2'h1, 11'h000);
    u_ctrl.auto_refresh_command(4'h5, 16'hFFFF);
    #1;
    chk({refr, rbanks}, 17'h10020);
    @(posedge mclk_in);
    #1;
    chk({refr, rbanks}, 17'h00020);
    u_ctrl.mode_register_set_command(2'h1, 11'h100);
    u_ctrl.auto_refresh_command(4'h0, 16'h8003);
    #1;
    chk({refr, rbanks}, 17'h18003);
    $display("test refresh done");
  endtask : t_refresh

  // Data termination drops for a read and returns after the last beat.
  task automatic t_term();
    u_ctrl.mode_register_set_command(2'h1, 11'h005);
    @(posedge mclk_in);
    rd_start <= 1'b1;
    #1;
    chk({dq_t, mck_t}, 2'h3);
    @(posedge mclk_in);
    rd_start <= 1'b0;
    #1;
    chk({dq_t, mck_t}, 2'h1);
    @(posedge mclk_in);
    rd_last <= 1'b1;
    #1;
    chk({dq_t, mck_t}, 2'h1);
    @(posedge mclk_in);
    rd_last <= 1'b0;
    #1;
    chk({dq_t, mck_t, drv}, 4'hD);
    $display("test termination done");
  endtask : t_term

  // Mid-run reset into the wide configuration, then the burst lengths there.
  task automatic t_wide();
    @(posedge mclk_in);
    t_reset(1'b1);
    u_ctrl.mode_register_set_command(2'h1, 11'h000);
    @(posedge mclk_in);
    #1;
    chk({bl_bad, aw}, {1'b0, mrc_pkg::AW_20});
    u_ctrl.mode_register_set_command(2'h1, 11'h200);
    @(posedge mclk_in);
    #1;
    chk({bl_bad, aw}, {1'b0, mrc_pkg::AW_19});
    u_ctrl.mode_register_set_command(2'h1, 11'h400);
    @(posedge mclk_in);
    #1;
    chk({bl_bad, bl}, {1'b1, mrc_pkg::BL_8});
    $display("test wide done");
  endtask : t_wide

  // Main sequence.
  initial begin
    t_reset(1'b0);
    t_fields();
    t_dll();
    t_cal();
    t_refresh();
    t_term();
    t_wide();
    final_report();
  end
endmodule : tb
